// *** logic/sspc_pkg.sv ***
// package: register map, field layouts, states and types of the serial port controller
`default_nettype none
package sspc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FCNT = 8'h04;
  localparam logic [7:0] OFF_EN = 8'h08;
  localparam logic [7:0] OFF_WIRE = 8'h0c;
  localparam logic [7:0] OFF_SSEL = 8'h10;
  localparam logic [7:0] OFF_DIV = 8'h14;
  localparam logic [7:0] OFF_TXT = 8'h18;
  localparam logic [7:0] OFF_RXT = 8'h1c;
  localparam logic [7:0] OFF_TXL = 8'h20;
  localparam logic [7:0] OFF_RXL = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  localparam logic [7:0] OFF_DATA = 8'h60;
  localparam logic [7:0] OFF_ROLE = 8'h64;
  // values after reset
  localparam logic [15:0] CTRL_RST = 16'h0007;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [1:0] ROLE_RST = 2'h0;
  // field widths
  localparam int LVL_W = 4;
  localparam int THR_W = 3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TM_TXRX = 2'h0,
    TM_TXO = 2'h1,
    TM_RXO = 2'h2,
    TM_MEMRD = 2'h3
  } sspc_transfer_mode_sel_e;

  typedef enum logic [1:0] {
    FF_CLKPH = 2'h0,
    FF_PULSE = 2'h1,
    FF_CWORD = 2'h2,
    FF_RSVD = 2'h3
  } sspc_frf_e;

  // master engine states, gray along idle, setup, shift
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PRE = 2'h1,
    ST_SHIFT = 2'h3
  } sspc_state_e;

  // main control word, laid out as in the register
  typedef struct packed {
    logic [3:0] ctrl_word_len;
    logic loopback_test;
    logic slave_tx_disable;
    sspc_transfer_mode_sel_e transfer_mode_sel;
    logic clk_idle_polarity;
    logic clk_phase_sel;
    sspc_frf_e frame_format_sel;
    logic [3:0] frame_len_sel;
  } sspc_ctrl_s;

  typedef struct packed {
    logic handshake_enable;
    logic word_direction;
    logic sequential_sel;
  } sspc_wire_s;

  typedef struct packed {
    logic collision_error;
    logic tx_underrun_error;
    logic rx_full_flag;
    logic rx_nonempty_flag;
    logic tx_empty_flag;
    logic tx_notfull_flag;
    logic busy;
  } sspc_stat_s;
endpackage
`default_nettype wire

// *** logic/sspc_top.sv ***
// serial port controller: axi4-lite registers, fifos, master and slave serial engines
//
// Added by the designer: register access over AXI4-Lite.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sspc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  // state
  output logic [W-1:0] rdata,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // a push into a full fifo or a pop from an empty one is dropped
  assign do_push = push && (cnt_q != CW'(DEPTH));
  assign do_pop = pop && (cnt_q != '0);
  assign rdata = mem_q[rp_q];
  assign count = cnt_q;

  // storage needs no reset, the count guards it
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem_q[wp_q] <= wdata;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sspc_top #(
  parameter int DEPTH = 8,
  parameter int PORT_IDX = 0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial pins, master role
  output logic m_sclk_o,
  output logic m_ss_n_o,
  output logic m_dout_o,
  input wire logic m_din_i,
  // serial pins, slave role
  input wire logic s_sclk_i,
  input wire logic s_ss_n_i,
  input wire logic s_din_i,
  output logic s_dout_o,
  output logic s_dout_oe_o,
  // fifo level flags
  output logic tx_below_thr_o,
  output logic rx_above_thr_o
);
  localparam int LW = sspc_pkg::LVL_W;
  // configuration
  sspc_pkg::sspc_ctrl_s ctrl_q;
  sspc_pkg::sspc_wire_s wire_q;
  logic [15:0] fcnt_q;
  logic [15:0] div_q;
  logic en_q;
  logic ssel_q;
  logic [2:0] txt_q;
  logic [2:0] rxt_q;
  logic [1:0] role_q;
  // bus slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, wmask, wmerged;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_go;
  logic [32:0] wview, rview;
  // fifos
  logic [31:0] tx_head, rx_head, rx_word, dmask;
  logic [LW-1:0] tx_cnt, rx_cnt;
  logic tx_push, rx_pop, eng_pop, eng_push;
  // synchronisers, stage 1 read only by stage 2
  logic sclk_s1, sclk_s2, sclk_s3, ss_s1, ss_s2, ss_s3;
  logic sdin_s1, sdin_s2, mdin_s1, mdin_s2;
  // engine
  sspc_pkg::sspc_state_e state_q, state_d;
  sspc_pkg::sspc_stat_s stat;
  logic [31:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [5:0] nbits, samp_q, samp_d;
  logic [6:0] ecnt_q, ecnt_d;
  logic [16:0] frames_q, frames_d;
  logic [15:0] hp_q, hp_d, half_m1;
  logic first_q, first_d, sclk_q, sclk_d;
  logic cpol, cpha, cword, pulse, mst_on, slv_on, slv_sel, slv_sel_q, pfr_q;
  logic m_tick, edge_ev, lead, sample, shift, s_end, rx_ok, tx_use, rx_in;
  logic urun_set, collision_error_set, urun_q, collision_error_q;
  logic [4:0] bit_idx;

  // register view; bit 32 marks a mapped offset
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    case (a)
      sspc_pkg::OFF_CTRL: reg_word = {1'h1, 16'h0, ctrl_q};
      sspc_pkg::OFF_FCNT: reg_word = {1'h1, 16'h0, fcnt_q};
      sspc_pkg::OFF_EN: reg_word = {1'h1, 31'h0, en_q};
      sspc_pkg::OFF_WIRE: reg_word = {1'h1, 29'h0, wire_q};
      sspc_pkg::OFF_SSEL: reg_word = {1'h1, 31'h0, ssel_q};
      sspc_pkg::OFF_DIV: reg_word = {1'h1, 16'h0, div_q};
      sspc_pkg::OFF_TXT: reg_word = {1'h1, 29'h0, txt_q};
      sspc_pkg::OFF_RXT: reg_word = {1'h1, 29'h0, rxt_q};
      sspc_pkg::OFF_TXL: reg_word = {1'h1, 28'h0, tx_cnt};
      sspc_pkg::OFF_RXL: reg_word = {1'h1, 28'h0, rx_cnt};
      sspc_pkg::OFF_STAT: reg_word = {1'h1, 25'h0, stat};
      sspc_pkg::OFF_DATA: reg_word = {1'h1, rx_head};
      sspc_pkg::OFF_ROLE: reg_word = {1'h1, 30'h0, role_q};
      default: reg_word = 33'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data are held until both are in, then one response
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign rd_go = arvalid && arready_q;

  // byte strobes merge the new data into the current value
  always_comb begin
    wview = reg_word(awaddr_q);
    rview = reg_word(araddr);
    for (int i = 0; i < 4; i++) begin
      wmask[8*i+:8] = {8{wstrb_q[i]}};
    end
    wmerged = (wview[31:0] & ~wmask) | (wdata_q & wmask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'h1;
      wready_q <= 1'h1;
      bvalid_q <= 1'h0;
      bresp_q <= sspc_pkg::RESP_OKAY;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'h0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'h0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'h1;
        bresp_q <= wview[32] ? sspc_pkg::RESP_OKAY : sspc_pkg::RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'h0;
        awready_q <= 1'h1;
        wready_q <= 1'h1;
      end
    end
  end

  // read data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'h1;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0;
      rresp_q <= sspc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h1;
      rdata_q <= rview[31:0];
      rresp_q <= rview[32] ? sspc_pkg::RESP_OKAY : sspc_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'h0;
      arready_q <= 1'h1;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sspc_pkg::sspc_ctrl_s'(sspc_pkg::CTRL_RST);
      wire_q <= '0;
      fcnt_q <= 16'h0;
      div_q <= 16'h0;
      en_q <= 1'h0;
      ssel_q <= 1'h0;
      txt_q <= 3'h0;
      rxt_q <= 3'h0;
      role_q <= sspc_pkg::ROLE_RST;
    end else if (wr_go) begin
      case (awaddr_q)
        sspc_pkg::OFF_CTRL: ctrl_q <= sspc_pkg::sspc_ctrl_s'(wmerged[15:0]);
        sspc_pkg::OFF_FCNT: fcnt_q <= wmerged[15:0];
        sspc_pkg::OFF_EN: en_q <= wmerged[0];
        sspc_pkg::OFF_WIRE: wire_q <= sspc_pkg::sspc_wire_s'(wmerged[2:0]);
        sspc_pkg::OFF_SSEL: ssel_q <= wmerged[0];
        sspc_pkg::OFF_DIV: div_q <= wmerged[15:0];
        sspc_pkg::OFF_TXT: txt_q <= wmerged[2:0];
        sspc_pkg::OFF_RXT: rxt_q <= wmerged[2:0];
        sspc_pkg::OFF_ROLE: role_q <= wmerged[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fifos, flushed while the controller is off
  assign tx_push = wr_go && (awaddr_q == sspc_pkg::OFF_DATA) && en_q;
  assign rx_pop = rd_go && (araddr == sspc_pkg::OFF_DATA);
  assign dmask = ~(32'hffff_ffff << (5'(ctrl_q.frame_len_sel) + 5'h1));
  assign rx_word = rx_sh_d & dmask;

  sspc_fifo #(.W(32), .DEPTH(DEPTH), .CW(LW)) u_txf (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!en_q),
    .push(tx_push),
    .wdata(wdata_q),
    .pop(eng_pop),
    .rdata(tx_head),
    .count(tx_cnt)
  );

  sspc_fifo #(.W(32), .DEPTH(DEPTH), .CW(LW)) u_rxf (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!en_q),
    .push(eng_push),
    .wdata(rx_word),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_cnt)
  );

  // pin inputs pass two flops; a third flop gives the slave clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {ss_s1, ss_s2, ss_s3} <= 3'h7;
      {sdin_s1, sdin_s2, mdin_s1, mdin_s2} <= 4'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {s_sclk_i, sclk_s1, sclk_s2};
      {ss_s1, ss_s2, ss_s3} <= {s_ss_n_i, ss_s1, ss_s2};
      {sdin_s1, sdin_s2, mdin_s1, mdin_s2} <= {s_din_i, sdin_s1, m_din_i, mdin_s1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // format decode; the reserved format code behaves as clock-phase format
  always_comb begin
    cword = ctrl_q.frame_format_sel == sspc_pkg::FF_CWORD;
    pulse = ctrl_q.frame_format_sel == sspc_pkg::FF_PULSE;
    cpol = ctrl_q.clk_idle_polarity;
    cpha = ctrl_q.clk_phase_sel;
    nbits = {2'h0, ctrl_q.frame_len_sel} + 6'h1;
    if (cword) begin
      cpol = 1'h0;
      cpha = 1'h0;
      nbits = {2'h0, ctrl_q.ctrl_word_len} + {2'h0, ctrl_q.frame_len_sel} + 6'h2;
    end else if (pulse) begin
      cpol = 1'h0;
      cpha = 1'h1;
    end
  end

  // one role at a time; the other engine is held idle
  assign mst_on = en_q && role_q[PORT_IDX];
  assign slv_on = en_q && !role_q[PORT_IDX];
  assign slv_sel = slv_on && (pulse ? pfr_q : !ss_s2);
  // divider halves give the two clock phases; below 2 runs at half aclk
  assign half_m1 = (div_q[15:1] == 15'h0) ? sspc_pkg::HALF_RST : {1'h0, div_q[15:1]} - 16'h1;
  assign m_tick = (state_q != sspc_pkg::ST_IDLE) && (hp_q == half_m1);
  assign edge_ev = mst_on ? (m_tick && state_q == sspc_pkg::ST_SHIFT)
                          : (slv_sel && slv_sel_q && (sclk_s2 != sclk_s3));
  assign lead = mst_on ? (sclk_q == cpol) : (sclk_s3 == cpol);
  // phase 0 samples on the leading edge, phase 1 on the trailing one
  assign sample = edge_ev && (lead ^ cpha);
  assign shift = edge_ev && !(lead ^ cpha) && (samp_q != 6'h0);
  assign s_end = !mst_on && sample && (samp_q == nbits - 6'h1);
  assign bit_idx = 5'(nbits - 6'h1);
  assign rx_in = ctrl_q.loopback_test ? tx_sh_q[bit_idx]
                                      : (mst_on ? mdin_s2 : sdin_s2);
  // no receive push in transmit-only, memory-read command frame, or outgoing word
  assign rx_ok = (ctrl_q.transfer_mode_sel != sspc_pkg::TM_TXO)
              && !(ctrl_q.transfer_mode_sel == sspc_pkg::TM_MEMRD && first_q)
              && !(cword && wire_q.word_direction);
  assign tx_use = ctrl_q.transfer_mode_sel == sspc_pkg::TM_TXRX
               || ctrl_q.transfer_mode_sel == sspc_pkg::TM_TXO;

  // engine next state: shifters, counters and master sequencing
  always_comb begin
    state_d = state_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    samp_d = samp_q;
    ecnt_d = ecnt_q;
    frames_d = frames_q;
    first_d = first_q;
    sclk_d = sclk_q;
    hp_d = hp_q + 16'h1;
    eng_pop = 1'h0;
    eng_push = 1'h0;
    urun_set = 1'h0;
    if (sample) begin
      rx_sh_d = {rx_sh_q[30:0], rx_in};
      samp_d = samp_q + 6'h1;
    end
    if (shift) begin
      tx_sh_d = {tx_sh_q[30:0], 1'h0};
    end
    if (mst_on) begin
      case (state_q)
        sspc_pkg::ST_IDLE: begin
          sclk_d = cpol;
          hp_d = 16'h0;
          // a written entry starts a burst; in receive-only mode it is a dummy, in memory-read mode it is the command
          if (tx_cnt != '0) begin
            eng_pop = 1'h1;
            tx_sh_d = tx_head;
            first_d = 1'h1;
            frames_d = {1'h0, fcnt_q} + 17'h1;
            samp_d = 6'h0;
            ecnt_d = 7'h0;
            state_d = sspc_pkg::ST_PRE;
          end
        end
        sspc_pkg::ST_PRE: begin
          if (m_tick) begin
            hp_d = 16'h0;
            // handshake: the slave raises its data line when ready
            if (!(cword && wire_q.handshake_enable) || mdin_s2) begin
              state_d = sspc_pkg::ST_SHIFT;
            end
          end
        end
        sspc_pkg::ST_SHIFT: begin
          if (m_tick) begin
            hp_d = 16'h0;
            sclk_d = !sclk_q;
            ecnt_d = ecnt_q + 7'h1;
            if (ecnt_q == {nbits, 1'h0} - 7'h1) begin
              eng_push = rx_ok;
              first_d = 1'h0;
              samp_d = 6'h0;
              ecnt_d = 7'h0;
              if (ctrl_q.transfer_mode_sel == sspc_pkg::TM_RXO
                  || (ctrl_q.transfer_mode_sel == sspc_pkg::TM_MEMRD && !first_q)) begin
                frames_d = frames_q - 17'h1;
              end
              state_d = sspc_pkg::ST_IDLE;
              if (tx_use && tx_cnt != '0) begin
                eng_pop = 1'h1;
                tx_sh_d = tx_head;
                state_d = sspc_pkg::ST_PRE;
              end else if (!tx_use && frames_d != 17'h0) begin
                tx_sh_d = 32'h0;
                state_d = sspc_pkg::ST_PRE;
              end
            end
          end
        end
        default: state_d = sspc_pkg::ST_IDLE;
      endcase
    end else begin
      state_d = sspc_pkg::ST_IDLE;
      sclk_d = cpol;
      hp_d = 16'h0;
      if (!slv_sel) begin
        samp_d = 6'h0;
      end
      if (s_end) begin
        eng_push = rx_ok;
        samp_d = 6'h0;
      end
      // a new frame loads at select, or, outside frame-pulse format, right after the last sample
      if (slv_sel && (!slv_sel_q || (s_end && !pulse))) begin
        tx_sh_d = 32'h0;
        if (ctrl_q.transfer_mode_sel != sspc_pkg::TM_RXO) begin
          if (tx_cnt != '0) begin
            eng_pop = 1'h1;
            tx_sh_d = tx_head;
          end else begin
            urun_set = 1'h1;
          end
        end
      end
    end
  end

  // engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sspc_pkg::ST_IDLE;
      tx_sh_q <= 32'h0;
      rx_sh_q <= 32'h0;
      samp_q <= 6'h0;
      ecnt_q <= 7'h0;
      frames_q <= 17'h0;
      first_q <= 1'h0;
      sclk_q <= 1'h0;
      hp_q <= 16'h0;
      slv_sel_q <= 1'h0;
    end else begin
      state_q <= state_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      samp_q <= samp_d;
      ecnt_q <= ecnt_d;
      frames_q <= frames_d;
      first_q <= first_d;
      sclk_q <= sclk_d;
      hp_q <= hp_d;
      slv_sel_q <= slv_sel;
    end
  end

  // frame-pulse slave: frame opens when the high pulse on select ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfr_q <= 1'h0;
    end else if (!slv_on || !pulse || s_end) begin
      pfr_q <= 1'h0;
    end else if (ss_s3 && !ss_s2) begin
      pfr_q <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // error flags: set wins over the clear that disabling the port gives
  assign collision_error_set = mst_on && (state_q != sspc_pkg::ST_IDLE) && !pulse && !ss_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      collision_error_q <= 1'h0;
      urun_q <= 1'h0;
    end else begin
      collision_error_q <= collision_error_set || (collision_error_q && en_q);
      urun_q <= urun_set || (urun_q && en_q);
    end
  end

  always_comb begin
    stat.collision_error = collision_error_q;
    stat.tx_underrun_error = urun_q;
    stat.rx_full_flag = rx_cnt == LW'(DEPTH);
    stat.rx_nonempty_flag = rx_cnt != '0;
    stat.tx_empty_flag = tx_cnt == '0;
    stat.tx_notfull_flag = tx_cnt != LW'(DEPTH);
    stat.busy = mst_on ? (state_q != sspc_pkg::ST_IDLE) : slv_sel;
  end

  // pins and flags, each straight from a flop; data follows next shifter value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_sclk_o <= 1'h0;
      m_ss_n_o <= 1'h1;
      m_dout_o <= 1'h0;
      s_dout_o <= 1'h0;
      s_dout_oe_o <= 1'h0;
      tx_below_thr_o <= 1'h1;
      rx_above_thr_o <= 1'h1;
    end else begin
      m_sclk_o <= mst_on ? sclk_d : 1'h0;
      if (pulse) begin
        m_ss_n_o <= mst_on && ssel_q && (state_d == sspc_pkg::ST_PRE);
      end else begin
        m_ss_n_o <= !(mst_on && ssel_q && (state_d == sspc_pkg::ST_SHIFT
          || (state_d == sspc_pkg::ST_PRE && !(cword && !wire_q.sequential_sel))));
      end
      m_dout_o <= (mst_on && state_d != sspc_pkg::ST_IDLE) ? tx_sh_d[bit_idx] : 1'h0;
      s_dout_o <= tx_sh_d[bit_idx];
      s_dout_oe_o <= slv_sel && !ctrl_q.slave_tx_disable
                  && (ctrl_q.transfer_mode_sel != sspc_pkg::TM_RXO);
      tx_below_thr_o <= tx_cnt <= {1'h0, txt_q};
      rx_above_thr_o <= rx_cnt >= {1'h0, rxt_q};
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
endmodule
`default_nettype wire

// *** verif/sspc_sva.sv ***
// checker: bus handshakes and pin relations of the serial port controller
`default_nettype none
module sspc_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // serial pins
  input wire logic m_sclk_o,
  input wire logic m_ss_n_o,
  input wire logic s_dout_oe_o
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken in one cycle
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> !awready && !wready ##1 bvalid)
    else $error("write answer missing");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_resp_legal: assert property (bvalid |-> bresp inside {2'h0, 2'h2})
    else $error("bad write response");
  a_no_overlap: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  a_rst_idle: assert property (disable iff (1'b0) !aresetn |=> m_ss_n_o && !m_sclk_o && !bvalid)
    else $error("outputs active in reset");
  a_one_engine: assert property (!$stable(m_sclk_o) |-> !s_dout_oe_o)
    else $error("both engines active");
endmodule

bind sspc_top sspc_sva i_sspc_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .m_sclk_o,
  .m_ss_n_o, .s_dout_oe_o);
`default_nettype wire

// *** verif/sspc_slave_model.sv ***
// partner: far-side serial slave, answers each frame with the previous one
`default_nettype none
module sspc_slave_model (
  // master pins of the device
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr_q = 8'h3c;
  // capture on the rising edge while selected, msb first
  always @(posedge sclk) if (!ss_n) sr_q <= {sr_q[6:0], mosi};
  // released line shows the inverse so a stale bit never passes
  assign miso = ss_n ? ~sr_q[7] : sr_q[7];
endmodule
`default_nettype wire

// *** verif/tb_sspc_top.sv ***
// testbench: registers, reset values and serial frames of the port controller
`default_nettype none
module tb_sspc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic s_sclk_i = 0, s_ss_n_i = 1, s_din_i = 0, awready, wready, bvalid, arready, rvalid;
  logic m_sclk_o, m_ss_n_o, m_dout_o, m_din_i, s_dout_o, s_dout_oe_o;
  logic tx_below_thr_o, rx_above_thr_o;
  logic [7:0] awaddr = 0, araddr = 0, x, far = 8'h3c;
  logic [31:0] wdata = 0, seed = 32'h2461, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [7:0] regs[$] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h28,
    8'h64, 8'h08};
  int num_errors = 0, n_compared = 0, mdl[int];
  sspc_top #(.DEPTH(8), .PORT_IDX(0)) i_sspc_top (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .m_sclk_o, .m_ss_n_o, .m_dout_o, .m_din_i,
    .s_sclk_i, .s_ss_n_i, .s_din_i, .s_dout_o, .s_dout_oe_o, .tx_below_thr_o, .rx_above_thr_o);
  sspc_slave_model i_sspc_slave_model (.sclk(m_sclk_o), .ss_n(m_ss_n_o), .mosi(m_dout_o),
    .miso(m_din_i));
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) s_din_i <= seed[3];
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // writable bits of each place; zero means read-only or unmapped
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h00, 8'h04, 8'h14: return 32'hffff;
      8'h08, 8'h10: return 32'h1;
      8'h0c, 8'h18, 8'h1c: return 32'h7;
      8'h64: return 32'h3;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bus write; model keeps only writable bits, reserved bits read zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    if (msk(a) != 0) mdl[a] = d & msk(a);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask
  initial begin
    foreach (regs[i]) mdl[regs[i]] = 0;
    mdl[0] = 7;
    mdl[8'h28] = 6;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, then random write and read back of every place except 0x24 and 0x60
    foreach (regs[i]) rd(regs[i], mdl[regs[i]], 2'h0);
    foreach (regs[i]) begin
      seed = xs(seed);
      wr(regs[i], seed, 2'h0);
      rd(regs[i], mdl[regs[i]], 2'h0);
    end
    chk(32'(tx_below_thr_o), 1);
    chk(32'(rx_above_thr_o), 32'(mdl[8'h1c] == 0));
    wr(8'h80, seed, 2'h2);
    rd(8'h80, 0, 2'h2);
    // master frames: loopback first, then against the far-side model
    wr(8'h08, 0, 2'h0);
    wr(8'h00, 32'h0807, 2'h0);
    wr(8'h14, 4, 2'h0);
    wr(8'h10, 1, 2'h0);
    wr(8'h64, 1, 2'h0);
    wr(8'h08, 1, 2'h0);
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      x = seed[7:0];
      if (k == 1) wr(8'h00, 32'h0007, 2'h0);
      wr(8'h60, 32'(x), 2'h0);
      repeat (100) @(posedge aclk);
      rd(8'h24, 1, 2'h0);
      rd(8'h20, 0, 2'h0);
      rd(8'h60, 32'(k == 0 ? x : far), 2'h0);
      chk(32'(m_sclk_o), 0);
      far = x;
    end
    // slave frame: bench clocks one byte in mode 0, slow enough for the synchronisers
    wr(8'h64, 0, 2'h0);
    wr(8'h60, 32'(x), 2'h0);
    s_ss_n_i <= 1'b0;
    repeat (8) @(posedge aclk);
    for (int b = 7; b >= 0; b--) begin
      seed = xs(seed);
      far[b] = seed[3];
      repeat (8) @(posedge aclk);
      chk(32'({s_dout_oe_o, s_dout_o}), 32'({1'b1, x[b]}));
      s_sclk_i <= 1'b1;
      repeat (8) @(posedge aclk);
      s_sclk_i <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    s_ss_n_i <= 1'b1;
    rd(8'h60, 32'(far), 2'h0);
    complete_run();
  end
  initial begin
    #50us;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
